// [hw/timer_rst_cfg.svh]
`ifndef TIMER_RST_CFG_SVH
`define TIMER_RST_CFG_SVH

// Register offsets
`define TRS_ADDR_RESET_SELECT 8'h00
`define TRS_ADDR_CONTROL 8'h01
`define TRS_ADDR_PERIOD 8'h02
`define TRS_ADDR_COUNT 8'h03
`define TRS_ADDR_STATUS 8'h04

// Field positions
`define TRS_RSEL_MSB 4
`define TRS_RSEL_LSB 0
`define TRS_CTRL_ON_BIT 7
`define TRS_CTRL_MODE_MSB 4
`define TRS_CTRL_MODE_LSB 0
`define TRS_STAT_LEVEL_BIT 0
`define TRS_STAT_VALID_BIT 1
`define TRS_STAT_ACTIVE_BIT 2
`define TRS_STAT_HELD_BIT 3

// Reset values
`define TRS_RSEL_RESET 5'h00
`define TRS_MODE_RESET 5'h00
`define TRS_PERIOD_RESET 8'hff
`define TRS_COUNT_RESET 8'h00

// Hardware-limit level modes
`define TRS_MODE_LEVEL_LOW 5'h16
`define TRS_MODE_LEVEL_HIGH 5'h17

// Source codes
`define TRS_SRC_PIN 5'h00
`define TRS_SRC_TIMER_FIRST 5'h01
`define TRS_SRC_TIMER_LAST 5'h03
`define TRS_SRC_CCP_FIRST 5'h04
`define TRS_SRC_CCP_LAST 5'h08
`define TRS_SRC_PWM_SIX 5'h09
`define TRS_SRC_PWM_SEVEN 5'h0a
`define TRS_SRC_CMP_ONE 5'h0b
`define TRS_SRC_CMP_TWO 5'h0c
`define TRS_SRC_ZCD 5'h0d
`define TRS_SRC_LC_FIRST 5'h0e
`define TRS_SRC_LC_LAST 5'h11

`endif

// [hw/timer_rst_pkg.sv]
package timer_rst_pkg;

    typedef struct packed {
        logic timer_input_pin_remap;
        logic [2:0] timer_postscaled_out;
        logic [4:0] capture_compare_out;
        logic pwm_six_out;
        logic pwm_seven_out;
        logic comparator_one_synced;
        logic comparator_two_synced;
        logic zero_cross_detect_out;
        logic [3:0] logic_cell_out;
    } sources_type;

    typedef struct packed {
        logic valid;
        logic level;
    } reset_pick_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic [4:0] reset_source_code;
        logic on;
        logic [4:0] mode;
        logic [7:0] period;
        logic [7:0] count;
        reset_pick_type pick;
        logic ext_reset_active;
        logic held;
        logic [7:0] rd_data;
        logic match;
    } state_type;

endpackage

// [hw/reset_source_mux.sv]
`include "timer_rst_cfg.svh"

module reset_source_mux #(
    parameter logic [1:0] OWN_TIMER = 2'd0
) (
    // Selection
    input wire logic [4:0] reset_source_code,
    input wire timer_rst_pkg::sources_type sources,
    // Picked signal
    output timer_rst_pkg::reset_pick_type pick
);

    function automatic timer_rst_pkg::reset_pick_type decode_source(
        input logic [4:0] code,
        input timer_rst_pkg::sources_type src,
        input logic [1:0] own
    );
        timer_rst_pkg::reset_pick_type r;
        logic [4:0] idx;
        r = '{valid: 1'b1, level: 1'b0};
        idx = 5'h00;
        if (code == `TRS_SRC_PIN) begin
            r.level = src.timer_input_pin_remap;
        end else if (code <= `TRS_SRC_TIMER_LAST) begin
            idx = code - `TRS_SRC_TIMER_FIRST;
            if (idx[1:0] == own) begin
                r.valid = 1'b0;
            end else begin
                r.level = src.timer_postscaled_out[idx[1:0]];
            end
        end else if (code <= `TRS_SRC_CCP_LAST) begin
            idx = code - `TRS_SRC_CCP_FIRST;
            r.level = src.capture_compare_out[idx[2:0]];
        end else if (code == `TRS_SRC_PWM_SIX) begin
            r.level = src.pwm_six_out;
        end else if (code == `TRS_SRC_PWM_SEVEN) begin
            r.level = src.pwm_seven_out;
        end else if (code == `TRS_SRC_CMP_ONE) begin
            r.level = src.comparator_one_synced;
        end else if (code == `TRS_SRC_CMP_TWO) begin
            r.level = src.comparator_two_synced;
        end else if (code == `TRS_SRC_ZCD) begin
            r.level = src.zero_cross_detect_out;
        end else if (code <= `TRS_SRC_LC_LAST) begin
            idx = code - `TRS_SRC_LC_FIRST;
            r.level = src.logic_cell_out[idx[1:0]];
        end else begin
            r.valid = 1'b0;
        end
        return r;
    endfunction

    assign pick = decode_source(reset_source_code, sources, OWN_TIMER);

endmodule // reset_source_mux

// [hw/timer_ext_reset_source_select.sv]
// Design decisions made here: the register addresses and the plain strobed port.
`include "timer_rst_cfg.svh"

module timer_ext_reset_source_select #(
    parameter logic [1:0] OWN_TIMER = 2'd0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire timer_rst_pkg::bus_req_type bus_req,
    output logic [7:0] rd_data,
    // Candidate reset sources
    input wire timer_rst_pkg::sources_type sources,
    // Timer side
    output logic ext_reset_active,
    output logic timer_held,
    output logic timer_on,
    output logic [7:0] count_value,
    output logic period_match
);

    timer_rst_pkg::state_type st_reg;
    timer_rst_pkg::state_type st_next;
    timer_rst_pkg::reset_pick_type pick;

    reset_source_mux #(
        .OWN_TIMER(OWN_TIMER)
    ) u_mux (
        .reset_source_code(st_reg.reset_source_code),
        .sources(sources),
        .pick(pick)
    );

    function automatic logic is_level_mode(input logic [4:0] mode);
        return (mode == `TRS_MODE_LEVEL_LOW) || (mode == `TRS_MODE_LEVEL_HIGH);
    endfunction

    function automatic logic at_reset_level(
        input logic [4:0] mode,
        input timer_rst_pkg::reset_pick_type p
    );
        logic r;
        r = 1'b0;
        if (p.valid) begin
            if (mode == `TRS_MODE_LEVEL_LOW) begin
                r = ~p.level;
            end else if (mode == `TRS_MODE_LEVEL_HIGH) begin
                r = p.level;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic sw_on_set;
        logic sw_on_clear;
        logic hw_on_clear;
        logic hit;
        sw_on_set = 1'b0;
        sw_on_clear = 1'b0;
        hw_on_clear = 1'b0;
        hit = 1'b0;
        st_next = st_reg;
        st_next.rd_data = 8'h00;

        // Register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `TRS_ADDR_RESET_SELECT: begin
                    st_next.reset_source_code =
                        bus_req.wdata[`TRS_RSEL_MSB:`TRS_RSEL_LSB];
                end
                `TRS_ADDR_CONTROL: begin
                    st_next.mode = bus_req.wdata[`TRS_CTRL_MODE_MSB:`TRS_CTRL_MODE_LSB];
                    sw_on_set = bus_req.wdata[`TRS_CTRL_ON_BIT];
                    sw_on_clear = ~bus_req.wdata[`TRS_CTRL_ON_BIT];
                end
                `TRS_ADDR_PERIOD: begin
                    st_next.period = bus_req.wdata;
                end
                default: begin
                end
            endcase
        end

        // Register reads
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `TRS_ADDR_RESET_SELECT: begin
                    st_next.rd_data = {3'h0, st_reg.reset_source_code};
                end
                `TRS_ADDR_CONTROL: begin
                    st_next.rd_data = {st_reg.on, 2'h0, st_reg.mode};
                end
                `TRS_ADDR_PERIOD: begin
                    st_next.rd_data = st_reg.period;
                end
                `TRS_ADDR_COUNT: begin
                    st_next.rd_data = st_reg.count;
                end
                `TRS_ADDR_STATUS: begin
                    st_next.rd_data = 8'h00;
                    st_next.rd_data[`TRS_STAT_LEVEL_BIT] = st_reg.pick.level;
                    st_next.rd_data[`TRS_STAT_VALID_BIT] = st_reg.pick.valid;
                    st_next.rd_data[`TRS_STAT_ACTIVE_BIT] = st_reg.ext_reset_active;
                    st_next.rd_data[`TRS_STAT_HELD_BIT] = st_reg.held;
                end
                default: begin
                    st_next.rd_data = 8'h00;
                end
            endcase
        end

        // Selected external reset level
        st_next.pick = pick;
        st_next.ext_reset_active = at_reset_level(st_reg.mode, pick);

        // Counting and hold in reset
        if (is_level_mode(st_reg.mode)) begin
            st_next.held = ~st_reg.on | st_reg.ext_reset_active;
        end else begin
            st_next.held = ~st_reg.on;
        end

        if (is_level_mode(st_reg.mode) && st_reg.held) begin
            st_next.count = `TRS_COUNT_RESET;
        end else if (st_reg.on && !st_reg.held) begin
            if (st_reg.count == st_reg.period) begin
                hit = 1'b1;
                st_next.count = `TRS_COUNT_RESET;
                hw_on_clear = is_level_mode(st_reg.mode);
            end else begin
                st_next.count = st_reg.count + 8'h01;
            end
        end

        // Software set wins over hardware clear
        if (sw_on_set) begin
            st_next.on = 1'b1;
        end else if (sw_on_clear || hw_on_clear) begin
            st_next.on = 1'b0;
        end
        st_next.match = hit;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.reset_source_code <= `TRS_RSEL_RESET;
            st_reg.on <= 1'b0;
            st_reg.mode <= `TRS_MODE_RESET;
            st_reg.period <= `TRS_PERIOD_RESET;
            st_reg.count <= `TRS_COUNT_RESET;
            st_reg.pick <= '{valid: 1'b0, level: 1'b0};
            st_reg.ext_reset_active <= 1'b0;
            st_reg.held <= 1'b1;
            st_reg.rd_data <= 8'h00;
            st_reg.match <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rd_data;
    assign ext_reset_active = st_reg.ext_reset_active;
    assign timer_held = st_reg.held;
    assign timer_on = st_reg.on;
    assign count_value = st_reg.count;
    assign period_match = st_reg.match;

endmodule // timer_ext_reset_source_select

// [verification/source_model.sv]
module source_model (
    // Clock and freeze control
    input wire logic sys_clk,
    input wire logic hold,
    // Candidate reset levels
    output timer_rst_pkg::sources_type sources
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h92ca;
    initial sources = '0;
    // Neighbouring outputs wander while not frozen
    always @(posedge sys_clk) begin
        if (!hold) begin
            sources <= 18'($random(seed));
        end
    end
endmodule // source_model

// [verification/timer_rst_assertions.sv]
module timer_rst_checker #(
    parameter logic [1:0] OWN_TIMER = 2'd0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire timer_rst_pkg::bus_req_type bus_req,
    input wire logic [7:0] rd_data,
    // Sources and timer side
    input wire timer_rst_pkg::sources_type sources,
    input wire logic ext_reset_active,
    input wire logic timer_held
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] code_reg;
    logic [4:0] mode_reg;
    logic lo;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Shadow of select and mode fields
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_reg <= 5'h00;
            mode_reg <= 5'h00;
        end else if (bus_req.wr && bus_req.addr == 8'h00) begin
            code_reg <= bus_req.wdata[4:0];
        end else if (bus_req.wr && bus_req.addr == 8'h01) begin
            mode_reg <= bus_req.wdata[4:0];
        end
    end
    assign lo = mode_reg == 5'h16;
    a_sel_readback: assert property (
        bus_req.rd && bus_req.addr == 8'h00 |=> rd_data == {3'h0, $past(code_reg)})
        else $error("select readback");
    a_reset_clear: assert property ($rose(arst_n) |-> rd_data == 8'h00 && !ext_reset_active)
        else $error("reset state");
    a_pin_route: assert property (
        code_reg == 5'h00 && lo |=> ext_reset_active == !$past(sources.timer_input_pin_remap))
        else $error("pin route");
    a_sibling_timer: assert property (
        code_reg == 5'h02 && lo && OWN_TIMER != 2'd1
        |=> ext_reset_active == !$past(sources.timer_postscaled_out[1]))
        else $error("timer route");
    a_own_reserved: assert property (
        code_reg == {3'h0, OWN_TIMER} + 5'h01 |=> !ext_reset_active)
        else $error("own timer code");
    a_ccp_route: assert property (
        code_reg == 5'h08 && lo |=> ext_reset_active == !$past(sources.capture_compare_out[4]))
        else $error("ccp route");
    a_zcd_high: assert property (
        code_reg == 5'h0d && mode_reg == 5'h17
        |=> ext_reset_active == $past(sources.zero_cross_detect_out))
        else $error("zcd route");
    a_cell_route: assert property (
        code_reg == 5'h11 && lo |=> ext_reset_active == !$past(sources.logic_cell_out[3]))
        else $error("cell route");
    a_reserved_idle: assert property (code_reg > 5'h11 |=> !ext_reset_active)
        else $error("reserved code");
    a_hold_follows: assert property (
        ext_reset_active && (mode_reg == 5'h16 || mode_reg == 5'h17) |=> timer_held)
        else $error("hold");
endmodule // timer_rst_checker

bind timer_ext_reset_source_select timer_rst_checker #(.OWN_TIMER(OWN_TIMER)) chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
    .sources(sources), .ext_reset_active(ext_reset_active), .timer_held(timer_held));

// [verification/timer_ext_reset_source_select_tb.sv]
module timer_ext_reset_source_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hold = 1'b0;
    timer_rst_pkg::bus_req_type bus_req = '0;
    timer_rst_pkg::sources_type sources;
    logic [7:0] rd_data;
    logic ext_reset_active;
    logic timer_held;
    logic timer_on;
    logic [7:0] count_value;
    logic period_match;
    int failures = 0;
    int n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    source_model src (.sys_clk(sys_clk), .hold(hold), .sources(sources));
    timer_ext_reset_source_select dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req),
        .rd_data(rd_data), .sources(sources), .ext_reset_active(ext_reset_active),
        .timer_held(timer_held), .timer_on(timer_on), .count_value(count_value),
        .period_match(period_match));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One write or read cycle, then idle
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge sys_clk);
        bus_req <= '0;
        #1;
    endtask
    // Reference pick: {valid, level}
    function automatic logic [1:0] pick(input int c, input timer_rst_pkg::sources_type s);
        logic t[18];
        t = '{s.timer_input_pin_remap, s.timer_postscaled_out[0], s.timer_postscaled_out[1],
            s.timer_postscaled_out[2], s.capture_compare_out[0], s.capture_compare_out[1],
            s.capture_compare_out[2], s.capture_compare_out[3], s.capture_compare_out[4],
            s.pwm_six_out, s.pwm_seven_out, s.comparator_one_synced, s.comparator_two_synced,
            s.zero_cross_detect_out, s.logic_cell_out[0], s.logic_cell_out[1],
            s.logic_cell_out[2], s.logic_cell_out[3]};
        return (c > 17 || c == 1) ? 2'b00 : {1'b1, t[c]};
    endfunction
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        logic [1:0] e;
        logic [4:0] md;
        logic act;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        access(8'h00, 8'h00, 1'b0);
        chk(rd_data, 8'h00);
        access(8'h00, 8'hff, 1'b1);
        access(8'h00, 8'h00, 1'b0);
        chk(rd_data, 8'h1f);
        access(8'h20, 8'h00, 1'b0);
        chk(rd_data, 8'h00);
        for (int c = 0; c < 18; c++) begin
            md = (c % 3 == 1) ? 5'h17 : 5'h16;
            @(posedge sys_clk);
            hold <= 1'b0;
            @(posedge sys_clk);
            hold <= 1'b1;
            access(8'h00, {3'h7, 5'(c)}, 1'b1);
            access(8'h01, {3'h0, md}, 1'b1);
            access(8'h01, {3'h4, md}, 1'b1);
            access(8'h00, 8'h00, 1'b0);
            chk(rd_data, {3'h0, 5'(c)});
            e = pick(c, sources);
            act = e[1] && (e[0] == (md == 5'h17));
            access(8'h04, 8'h00, 1'b0);
            chk(rd_data, {4'h0, act, act, e});
            chk({7'h0, ext_reset_active}, {7'h0, act});
            chk(count_value, act ? 8'h00 : 8'h03);
        end
        // Deliberate reserved code probe, then a one-shot of period three
        access(8'h00, 8'h1f, 1'b1);
        access(8'h02, 8'h03, 1'b1);
        access(8'h01, 8'h16, 1'b1);
        access(8'h01, 8'h96, 1'b1);
        for (int k = 0; k < 7; k++) begin
            chk(count_value, 8'((k >= 2 && k <= 4) ? k - 1 : 0));
            chk({7'h0, period_match}, {7'h0, k == 5});
            chk({7'h0, timer_on}, {7'h0, k < 5});
            @(posedge sys_clk);
            #1;
        end
        chk({7'h0, ext_reset_active}, 8'h00);
        // Mid-run reset clears a nonzero code
        access(8'h00, 8'h05, 1'b1);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        access(8'h00, 8'h00, 1'b0);
        chk(rd_data, 8'h00);
        close_out();
    end
endmodule // timer_ext_reset_source_select_tb
